// *** rtl/ircs_consts.svh ***
// constants of the serial control slave: address, subaddress map, lengths, timing
`ifndef IRCS_CONSTS_SVH
`define IRCS_CONSTS_SVH

// ****************************************
// bus addressing
// ****************************************
`define IRCS_DEV_ADDR 7'h1B
`define IRCS_APPEND_SUB 8'hFE

// ****************************************
// subaddress classes and byte lengths
// ****************************************
`define IRCS_MIX_BASE 8'h20
`define IRCS_BQ_BASE 8'h50
`define IRCS_BQ_END 8'h80
`define IRCS_LEN_GEN 5'h01
`define IRCS_LEN_MIX 5'h04
`define IRCS_LEN_BQ 5'h14

// ****************************************
// byte kinds within a frame
// ****************************************
`define IRCS_K_ADDR 2'h0
`define IRCS_K_SUB 2'h1
`define IRCS_K_DATA 2'h2

// ****************************************
// timing
// ****************************************
`define IRCS_STD_KHZ 100
`define IRCS_FAST_KHZ 400
`define IRCS_SYS_MHZ 250
`define IRCS_LINK_KHZ 12500
`define IRCS_MIN_SAMPLES 8

`endif

// *** rtl/ircs_pkg.sv ***
// types shared by the serial control slave
package ircs_pkg;
    typedef enum logic [4:0] {
        IRCS_IDLE = 5'b00001,
        IRCS_RX = 5'b00010,
        IRCS_ACK = 5'b00100,
        IRCS_TX = 5'b01000,
        IRCS_RACK = 5'b10000
    } ircs_state_e;
    typedef logic [7:0] ircs_byte_t;
    typedef logic [31:0] ircs_word_t;
endpackage

// *** rtl/ircs_mem.sv ***
// register store: one write port, one read port with registered read data
`timescale 1ns/1ns
module ircs_mem #(
    parameter int W = 32,
    parameter int AW = 11
) (
    input wire logic i_clk,
    input wire logic i_ce,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [W-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [W-1:0] o_rdata
);
    // no reset on the array: contents survive any block reset, as power-down expects
    logic [W-1:0] mem [0:(1<<AW)-1];

    generate
        if (W < 8 || AW < 1) begin : g_chk
            $error("ircs_mem: width or depth too small");
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (i_ce && i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule

// *** rtl/ircs_slave.sv ***
// serial control slave: two-wire bus engine, write staging, commit and read-back
// Behaviour
// - works at 100 kHz and 400 kHz clocks
// - never stretches the bus clock
// - bytes are eight bits, MSB first
// - receiver acknowledges each byte next period
// - data changes only while clock low
// - matching address is acknowledged low throughout
// - answer only the fixed seven-bit address
// - no byte limit between start, stop
// - lines open-drain, only pulled low
// - general byte access, coefficients in words
// - reads stream bytes while master acknowledges
// - unused bits of short registers read zero
// - count write bytes against subaddress length
// - filter five words, mixer one word
// - partial filter write ending mid-word discarded at stop/start
// - sequential write steps through subaddresses
// - only incomplete last subaddress dropped
// - power-down leaves registers untouched
// - append subaddress continues an open register
// - open append flushed on error cases
`timescale 1ns/1ns
`include "ircs_consts.svh"
module ircs_slave import ircs_pkg::*; #(
    parameter int LINK_KHZ = `IRCS_LINK_KHZ,
    parameter int SYS_MHZ = `IRCS_SYS_MHZ
) (
    input wire logic I_CLOCK,
    input wire logic I_NRST,
    input wire logic I_CE,
    input wire logic I_LINK_CLOCK,
    input wire logic I_SCL,
    input wire logic I_SDA,
    input wire logic I_POWER_DOWN_INPUT_N,
    output logic O_SCL_OUT,
    output logic O_SCL_OE,
    output logic O_SDA_OUT,
    output logic O_SDA_OE,
    output logic O_COMMIT,
    output logic [7:0] O_COMMIT_SUB,
    output logic O_POWER_DOWN
);
    // ****************************************
    // elaboration checks
    // ****************************************
    localparam int MIN_LINK_KHZ = `IRCS_FAST_KHZ * `IRCS_MIN_SAMPLES;
    generate
        if (LINK_KHZ < MIN_LINK_KHZ || SYS_MHZ * 1000 < 4 * LINK_KHZ) begin : g_chk
            $error("ircs_slave: sampling clock too slow for fast-mode bus");
        end
    endgenerate

    function automatic logic [4:0] len_of(input ircs_byte_t sub);
        if (sub >= `IRCS_BQ_BASE && sub < `IRCS_BQ_END) begin
            len_of = `IRCS_LEN_BQ;
        end else if (sub >= `IRCS_MIX_BASE && sub < `IRCS_BQ_BASE) begin
            len_of = `IRCS_LEN_MIX;
        end else begin
            len_of = `IRCS_LEN_GEN;
        end
    endfunction

    // ****************************************
    // link domain: pin sampling and glitch filter
    // ****************************************
    // the sampling clock is free running and independent of the audio clock
    logic [2:0] scl_pin;
    logic [2:0] sda_pin;
    logic scl_f;
    logic sda_f;
    always_ff @(posedge I_LINK_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            scl_pin <= 3'h7;
            sda_pin <= 3'h7;
        end else begin
            scl_pin <= {scl_pin[1:0], I_SCL};
            sda_pin <= {sda_pin[1:0], I_SDA};
        end
    end
    always_ff @(posedge I_LINK_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            scl_f <= 1'b1;
            sda_f <= 1'b1;
        end else begin
            if (scl_pin[1] == scl_pin[2]) begin
                scl_f <= scl_pin[2];
            end
            if (sda_pin[1] == sda_pin[2]) begin
                sda_f <= sda_pin[2];
            end
        end
    end

    // ****************************************
    // crossing of filtered levels, edge and condition detection
    // ****************************************
    logic scl_m1;
    logic scl_m2;
    logic scl_p;
    logic sda_m1;
    logic sda_m2;
    logic sda_p;
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            scl_m1 <= 1'b1;
            scl_m2 <= 1'b1;
            scl_p <= 1'b1;
            sda_m1 <= 1'b1;
            sda_m2 <= 1'b1;
            sda_p <= 1'b1;
        end else if (I_CE) begin
            scl_m1 <= scl_f;
            scl_m2 <= scl_m1;
            scl_p <= scl_m2;
            sda_m1 <= sda_f;
            sda_m2 <= sda_m1;
            sda_p <= sda_m2;
        end
    end
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    assign scl_rise = scl_m2 && !scl_p;
    assign scl_fall = !scl_m2 && scl_p;
    assign start_ev = scl_m2 && scl_p && sda_p && !sda_m2;
    assign stop_ev = scl_m2 && scl_p && !sda_p && sda_m2;

    // ****************************************
    // power-down pin: seen, but never touches stored registers
    // ****************************************
    logic [2:0] pdn_s;
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            pdn_s <= 3'h7;
            O_POWER_DOWN <= 1'b0;
        end else if (I_CE) begin
            pdn_s <= {pdn_s[1:0], I_POWER_DOWN_INPUT_N};
            if (pdn_s[1] == pdn_s[2]) begin
                O_POWER_DOWN <= !pdn_s[2];
            end
        end
    end

    // ****************************************
    // bus engine
    // ****************************************
    ircs_state_e st;
    logic [3:0] bitcnt;
    ircs_byte_t rxsh;
    ircs_byte_t txsh;
    logic [1:0] kind;
    logic rw;
    ircs_byte_t rbyte;
    logic byte_done;
    logic addr_done;
    logic addr_hit;
    logic rd_open;
    logic sub_done;
    logic dat_done;
    logic rack_ack;
    assign byte_done = scl_fall && st == IRCS_RX && bitcnt == 4'h8;
    assign addr_done = byte_done && kind == `IRCS_K_ADDR;
    assign addr_hit = rxsh[7:1] == `IRCS_DEV_ADDR;
    assign rd_open = addr_done && addr_hit && rxsh[0];
    assign sub_done = byte_done && kind == `IRCS_K_SUB;
    assign dat_done = byte_done && kind == `IRCS_K_DATA;
    assign rack_ack = st == IRCS_RACK && scl_rise && !sda_m2;

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            st <= IRCS_IDLE;
            bitcnt <= 4'h0;
            rxsh <= 8'h00;
            txsh <= 8'h00;
            kind <= `IRCS_K_ADDR;
            rw <= 1'b0;
            O_SDA_OE <= 1'b0;
        end else if (I_CE) begin
            if (start_ev) begin
                st <= IRCS_RX;
                bitcnt <= 4'h0;
                kind <= `IRCS_K_ADDR;
                O_SDA_OE <= 1'b0;
            end else if (stop_ev) begin
                st <= IRCS_IDLE;
                O_SDA_OE <= 1'b0;
            end else begin
                case (st)
                    IRCS_RX: begin
                        if (scl_rise && bitcnt < 4'h8) begin
                            rxsh <= {rxsh[6:0], sda_m2};
                            bitcnt <= bitcnt + 4'h1;
                        end else if (byte_done) begin
                            bitcnt <= 4'h0;
                            if (kind == `IRCS_K_ADDR && !addr_hit) begin
                                st <= IRCS_IDLE;
                            end else begin
                                st <= IRCS_ACK;
                                O_SDA_OE <= 1'b1;
                                if (kind == `IRCS_K_ADDR) begin
                                    rw <= rxsh[0];
                                    kind <= `IRCS_K_SUB;
                                end else begin
                                    kind <= `IRCS_K_DATA;
                                end
                            end
                        end
                    end
                    IRCS_ACK: begin
                        if (scl_fall) begin
                            if (rw) begin
                                st <= IRCS_TX;
                                txsh <= rbyte;
                                O_SDA_OE <= !rbyte[7];
                            end else begin
                                st <= IRCS_RX;
                                O_SDA_OE <= 1'b0;
                            end
                        end
                    end
                    IRCS_TX: begin
                        if (scl_fall) begin
                            bitcnt <= bitcnt + 4'h1;
                            if (bitcnt == 4'h7) begin
                                st <= IRCS_RACK;
                                bitcnt <= 4'h0;
                                O_SDA_OE <= 1'b0;
                            end else begin
                                txsh <= {txsh[6:0], 1'b0};
                                O_SDA_OE <= !txsh[6];
                            end
                        end
                    end
                    IRCS_RACK: begin
                        if (scl_rise) begin
                            rxsh[0] <= sda_m2;
                        end else if (scl_fall) begin
                            if (!rxsh[0]) begin
                                st <= IRCS_TX;
                                txsh <= rbyte;
                                O_SDA_OE <= !rbyte[7];
                            end else begin
                                st <= IRCS_IDLE;
                            end
                        end
                    end
                    IRCS_IDLE: begin
                        O_SDA_OE <= 1'b0;
                    end
                    default: begin
                        st <= IRCS_IDLE;
                        O_SDA_OE <= 1'b0;
                    end
                endcase
            end
        end
    end

    // the clock line is never driven and data is only ever pulled low
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_SCL_OE <= 1'b0;
            O_SCL_OUT <= 1'b0;
            O_SDA_OUT <= 1'b0;
        end else if (I_CE) begin
            O_SCL_OE <= 1'b0;
            O_SCL_OUT <= 1'b0;
            O_SDA_OUT <= 1'b0;
        end
    end

    // ****************************************
    // write staging and append
    // ****************************************
    logic open;
    logic drop;
    logic [4:0] cnt;
    ircs_byte_t wsub;
    ircs_word_t stage [0:4];
    logic creq;
    ircs_byte_t creq_sub;
    logic [2:0] creq_last;
    logic [4:0] wlen;
    assign wlen = len_of(wsub);
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            open <= 1'b0;
            drop <= 1'b0;
            cnt <= 5'h00;
            wsub <= 8'h00;
            creq <= 1'b0;
            creq_sub <= 8'h00;
            creq_last <= 3'h0;
        end else if (I_CE) begin
            creq <= 1'b0;
            if (rd_open) begin
                open <= 1'b0;
                cnt <= 5'h00;
            end else if (sub_done && rxsh == `IRCS_APPEND_SUB) begin
                drop <= !open;
            end else if (sub_done) begin
                open <= 1'b0;
                drop <= 1'b0;
                cnt <= 5'h00;
                wsub <= rxsh;
            end else if (dat_done && !drop) begin
                if (cnt + 5'h01 == wlen) begin
                    creq <= 1'b1;
                    creq_sub <= wsub;
                    creq_last <= cnt[4:2];
                    wsub <= wsub + 8'h01;
                    cnt <= 5'h00;
                    open <= 1'b0;
                end else begin
                    cnt <= cnt + 5'h01;
                    open <= 1'b1;
                end
            end else if ((start_ev || stop_ev) && open && (cnt[1:0] != 2'h0 || wlen < `IRCS_LEN_MIX)) begin
                open <= 1'b0;
                cnt <= 5'h00;
            end
        end
    end
    // short registers keep zero above their byte
    always_ff @(posedge I_CLOCK) begin
        if (I_CE && dat_done && !drop) begin
            if (cnt[1:0] == 2'h0) begin
                stage[cnt[4:2]] <= {24'h00_0000, rxsh};
            end else begin
                stage[cnt[4:2]] <= {stage[cnt[4:2]][23:0], rxsh};
            end
        end
    end

    // ****************************************
    // commit of a completed register into the store
    // ****************************************
    logic cbusy;
    logic [2:0] cidx;
    logic [2:0] clast;
    ircs_byte_t csub;
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            cbusy <= 1'b0;
            cidx <= 3'h0;
            clast <= 3'h0;
            csub <= 8'h00;
            O_COMMIT <= 1'b0;
            O_COMMIT_SUB <= 8'h00;
        end else if (I_CE) begin
            O_COMMIT <= 1'b0;
            if (creq) begin
                cbusy <= 1'b1;
                cidx <= 3'h0;
                clast <= creq_last;
                csub <= creq_sub;
            end else if (cbusy) begin
                cidx <= cidx + 3'h1;
                if (cidx == clast) begin
                    cbusy <= 1'b0;
                    O_COMMIT <= 1'b1;
                    O_COMMIT_SUB <= csub;
                end
            end
        end
    end

    // ****************************************
    // read pointer and byte selection
    // ****************************************
    ircs_byte_t rsub;
    logic [4:0] ridx;
    ircs_word_t rword;
    logic [4:0] rlen;
    assign rlen = len_of(rsub);
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            rsub <= 8'h00;
            ridx <= 5'h00;
        end else if (I_CE) begin
            if (sub_done) begin
                rsub <= rxsh;
                ridx <= 5'h00;
            end else if (rack_ack) begin
                if (ridx + 5'h01 == rlen) begin
                    rsub <= rsub + 8'h01;
                    ridx <= 5'h00;
                end else begin
                    ridx <= ridx + 5'h01;
                end
            end
        end
    end
    always_comb begin
        case (ridx[1:0])
            2'h0: rbyte = rword[31:24];
            2'h1: rbyte = rword[23:16];
            2'h2: rbyte = rword[15:8];
            default: rbyte = rword[7:0];
        endcase
        if (rlen < `IRCS_LEN_MIX) begin
            rbyte = rword[7:0];
        end
    end

    ircs_mem #(.W(32), .AW(11)) u_mem (
        .i_clk(I_CLOCK),
        .i_ce(I_CE),
        .i_we(cbusy),
        .i_waddr({csub, cidx}),
        .i_wdata(stage[cidx]),
        .i_raddr({rsub, ridx[4:2]}),
        .o_rdata(rword)
    );

    // ****************************************
    // checks
    // ****************************************
    sequence seq_addr_miss;
        addr_done && !addr_hit;
    endsequence
    sequence seq_write_end_partial;
        (start_ev || stop_ev) && open && cnt[1:0] != 2'h0 && !dat_done;
    endsequence

    no_clock_stretch_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) !O_SCL_OE)
        else $error("clock line driven");
    sda_low_change_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        I_CE && O_SDA_OE != $past(O_SDA_OE) && !$past(start_ev || stop_ev) |-> !scl_m2)
        else $error("data changed while clock high");
    ack_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        I_CE && addr_done && addr_hit ##1 I_CE[*1] |-> O_SDA_OE throughout (st == IRCS_ACK)[*1])
        else $error("address ack not driven");
    addr_miss_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        I_CE and seq_addr_miss |=> st == IRCS_IDLE && !O_SDA_OE)
        else $error("foreign address answered");
    tx_msb_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        st == IRCS_TX |-> O_SDA_OE == !txsh[7])
        else $error("read bit not msb first");
    bit_count_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) bitcnt <= 4'h8)
        else $error("byte longer than eight bits");
    partial_drop_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        I_CE and seq_write_end_partial |=> !open && cnt == 5'h00)
        else $error("partial write kept");
    read_flush_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        I_CE && rd_open |=> !open)
        else $error("append not flushed on read");
    commit_len_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        I_CE && creq && creq_last == 3'h4 ##1 I_CE[*5] |=> O_COMMIT)
        else $error("filter commit length wrong");
    sda_pull_only_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) !O_SDA_OUT)
        else $error("data line driven high");
endmodule

// *** test/ircs_host_model.sv ***
// bus master model for the two-wire control bus, host side
`timescale 1ns/1ns
module ircs_host_model (
    input wire logic i_sda,
    output logic o_scl_pull,
    output logic o_sda_pull
);
    // half bit time in ns; steps of 160 keep every change on the drive edge and at one sampling phase
    int half = 320;
    initial begin
        o_scl_pull = 1'b0;
        o_sda_pull = 1'b0;
    end
    // ****************************************
    // conditions
    // ****************************************
    task automatic start();
        o_sda_pull = 1'b0;
        #(half);
        o_scl_pull = 1'b0;
        #(half);
        o_sda_pull = 1'b1;
        #(half);
        o_scl_pull = 1'b1;
    endtask
    task automatic stop();
        #(half / 2);
        o_sda_pull = 1'b1;
        #(half / 2);
        o_scl_pull = 1'b0;
        #(half);
        o_sda_pull = 1'b0;
        #(half);
    endtask
    // ****************************************
    // bits and bytes
    // ****************************************
    // data moves mid low phase, so a slow filter in the slave never sees it near the clock edge
    task automatic bit_io(input logic b, output logic r);
        #(half / 2);
        o_sda_pull = !b;
        #(half / 2);
        o_scl_pull = 1'b0;
        #(half);
        r = i_sda;
        o_scl_pull = 1'b1;
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic recv(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(!more, r);
    endtask
endmodule

// *** test/test_i2c_register_control_slave.sv ***
// self-checking bench for the serial control slave
`timescale 1ns/1ns
`include "ircs_consts.svh"
module test_i2c_register_control_slave import ircs_pkg::*;;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic pdn_n = 1'b1;
    logic stretched = 1'b0;
    logic scl_pull, sda_pull, scl_oe, scl_out, sda_oe, sda_out, commit, pwr_down;
    logic [7:0] commit_sub;
    wire scl = !(scl_oe | scl_pull);
    wire sda = !(sda_oe | sda_pull);
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    ircs_byte_t tx[32];
    ircs_byte_t rx[32];
    ircs_byte_t seen[$];
    always #2 clk = !clk;
    initial begin
        #13;
        forever #40 link_clk = !link_clk;
    end
    ircs_slave dut_u (.I_CLOCK(clk), .I_NRST(nrst), .I_CE(ce), .I_LINK_CLOCK(link_clk), .I_SCL(scl),
        .I_SDA(sda), .I_POWER_DOWN_INPUT_N(pdn_n), .O_SCL_OUT(scl_out), .O_SCL_OE(scl_oe),
        .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .O_COMMIT(commit), .O_COMMIT_SUB(commit_sub),
        .O_POWER_DOWN(pwr_down));
    ircs_host_model host_u (.i_sda(sda), .o_scl_pull(scl_pull), .o_sda_pull(sda_pull));
    // ****************************************
    // monitors and report
    // ****************************************
    always @(posedge clk) begin
        cycles++;
        if (commit === 1'b1) seen.push_back(commit_sub);
        if (nrst && (scl_oe !== 1'b0 || scl_out !== 1'b0 || sda_out !== 1'b0)) stretched = 1'b1;
        // traffic takes about 81000 cycles
        if (cycles == 95000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic conclude();
        if (n_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input ircs_byte_t exp, input ircs_byte_t got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk1(input string name, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %b seen %b", name, exp, got);
        end
    endtask
    // ****************************************
    // frames
    // ****************************************
    task automatic put(input ircs_byte_t d);
        logic a;
        host_u.send(d, a);
        chk1("ack", 1'b1, a);
    endtask
    task automatic wr(input ircs_byte_t sub, input int n);
        host_u.start();
        put({`IRCS_DEV_ADDR, 1'b0});
        put(sub);
        for (int i = 0; i < n; i++) put(tx[i]);
        host_u.stop();
    endtask
    task automatic rd(input ircs_byte_t sub, input int n);
        host_u.start();
        put({`IRCS_DEV_ADDR, 1'b0});
        put(sub);
        host_u.start();
        put({`IRCS_DEV_ADDR, 1'b1});
        for (int i = 0; i < n; i++) host_u.recv(i < n - 1, rx[i]);
        host_u.stop();
    endtask
    // commit lands a few clocks after the last data bit, long before the stop ends
    task automatic commits(input ircs_byte_t a, input ircs_byte_t b, input int n);
        repeat (20) @(negedge clk);
        chk("commit count", 8'(n), 8'(seen.size()));
        if (n > 0) chk("commit sub", a, seen[0]);
        if (n > 1) chk("commit sub", b, seen[1]);
        seen.delete();
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_address();
        logic a;
        host_u.start();
        host_u.send({`IRCS_DEV_ADDR ^ 7'h01, 1'b0}, a);
        chk1("foreign ack", 1'b0, a);
        host_u.stop();
        // one frame just under the fast-mode limit, keeping the phase to the sampling clock
        host_u.half = 1280;
        host_u.start();
        put({`IRCS_DEV_ADDR, 1'b0});
        host_u.stop();
        host_u.half = 320;
    endtask
    task automatic t_single();
        tx[0] = 8'hA5;
        wr(8'h05, 1);
        commits(8'h05, 8'h00, 1);
        pdn_n = 1'b0;
        for (int i = 0; i < 400 && pwr_down !== 1'b1; i++) @(negedge clk);
        chk1("power down", 1'b1, pwr_down);
        pdn_n = 1'b1;
        for (int i = 0; i < 400 && pwr_down !== 1'b0; i++) @(negedge clk);
        chk1("power down", 1'b0, pwr_down);
        rd(8'h05, 1);
        chk("kept byte", 8'hA5, rx[0]);
    endtask
    task automatic t_seq();
        for (int i = 0; i < 7; i++) tx[i] = 8'(8'h11 * (i + 3));
        wr(8'h1F, 7);
        commits(8'h1F, `IRCS_MIX_BASE, 2);
        rd(`IRCS_MIX_BASE, 4);
        for (int i = 0; i < 4; i++) chk("mixer byte", tx[i + 1], rx[i]);
    endtask
    task automatic t_filter();
        for (int i = 0; i < 20; i++) tx[i] = 8'(i * 7 + 1);
        wr(`IRCS_BQ_BASE, 8);
        commits(8'h00, 8'h00, 0);
        for (int i = 0; i < 12; i++) tx[i] = tx[i + 8];
        wr(`IRCS_APPEND_SUB, 12);
        commits(`IRCS_BQ_BASE, 8'h00, 1);
    endtask
    initial begin
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        repeat (200) @(negedge clk);
        t_address();
        t_single();
        t_seq();
        t_filter();
        chk1("clock stretch", 1'b0, stretched);
        conclude();
    end
endmodule
